// >>> hw/fsr_consts.svh
// Constants for the field-oriented control readback register bank.
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define FSR_IDX_W          11
`define FSR_IDX_ALPHA      11'h4D8
`define FSR_IDX_BETA       11'h4DA
`define FSR_IDX_DCUR       11'h4E4
`define FSR_IDX_QCUR       11'h4E6
`define FSR_IDX_DVOLT      11'h4E8
`define FSR_IDX_QVOLT      11'h4EA
`define FSR_IDX_ALIGN      11'h524
`define FSR_IDX_SPEED      11'h53A

// Byte address width of the slave port.
`define FSR_ADDR_W         13
`define FSR_BYTE_SHIFT     2

// Position of each register in the store.
`define FSR_N_REGS         8
`define FSR_POS_ALPHA      0
`define FSR_POS_BETA       1
`define FSR_POS_DCUR       2
`define FSR_POS_QCUR       3
`define FSR_POS_DVOLT      4
`define FSR_POS_QVOLT      5
`define FSR_POS_ALIGN      6
`define FSR_POS_SPEED      7

// Word layout and reset value.
`define FSR_DATA_W         32
`define FSR_RESET_WORD     32'h00000000

// Avalon-MM response codes.
`define FSR_RESP_OKAY      2'h0
`define FSR_RESP_SLVERR    2'h2

`endif

// >>> hw/fsr_pkg.sv
// Types shared by the field-oriented control readback register bank.
package fsr_pkg;

   typedef logic [31:0] fsr_word_t;

   // Values from the control loop; the first field sits in the top bits.
   typedef struct packed {
      fsr_word_t open_loop_speed_reference;
      fsr_word_t align_current_reference;
      fsr_word_t quadrature_axis_voltage;
      fsr_word_t direct_axis_voltage;
      fsr_word_t quadrature_axis_current;
      fsr_word_t direct_axis_current;
      fsr_word_t beta_axis_voltage;
      fsr_word_t alpha_axis_voltage;
   } fsr_values_s;

endpackage

// >>> hw/fsr_regs.sv
// Read-only readback bank of the field-oriented control loop behind an Avalon-MM slave.
`include "fsr_consts.svh"

// What this block does
// - Alpha-axis voltage readable as signed word; volts = word/2^27*60/sqrt(3).
// - Beta-axis voltage readable at index 4DAh, same voltage scale.
// - Estimated direct-axis current at index 4E4h; amperes = word/2^27*1.25.
// - Estimated quadrature-axis current at index 4E6h; amperes = word/2^27*1.25.
// - Applied direct-axis voltage at index 4E8h, voltage scale.
// - Applied quadrature-axis voltage at index 4EAh, voltage scale.
// - Rotor alignment current reference at index 524h, current scale.
// - Open-loop speed reference at index 53Ah; hertz = word/2^27*full-scale speed.
// - Every register reads zero after reset until the control loop updates it.

module fsr_regs #(
   parameter int ADDR_W = `FSR_ADDR_W
) (
   input  wire logic                 clock,
   input  wire logic                 reset_n,
   input  wire logic [ADDR_W-1:0]    avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic      [31:0]          avs_readdata,
   output logic      [1:0]           avs_response,
   output logic                      avs_waitrequest,
   input  wire fsr_pkg::fsr_values_s values,
   input  wire logic [`FSR_N_REGS-1:0] update
);

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------

   localparam int N = `FSR_N_REGS;

   localparam logic [`FSR_IDX_W-1:0] IDX_TAB [N] = '{
      `FSR_IDX_ALPHA,
      `FSR_IDX_BETA,
      `FSR_IDX_DCUR,
      `FSR_IDX_QCUR,
      `FSR_IDX_DVOLT,
      `FSR_IDX_QVOLT,
      `FSR_IDX_ALIGN,
      `FSR_IDX_SPEED
   };

   logic [N*32-1:0]        value_flat;
   logic [N*32-1:0]        store_flat;
   logic [`FSR_IDX_W-1:0]  word_idx;
   logic [N-1:0]           hit;
   logic                   mapped;
   logic                   req;
   logic [31:0]            store_q [N];
   logic [31:0]            store_d [N];
   logic                   ack_q;
   logic                   ack_d;
   logic [31:0]            rdata_q;
   logic [31:0]            rdata_d;
   logic [1:0]             resp_q;
   logic [1:0]             resp_d;
   logic                   seen_q;
   logic                   seen_d;

   assign value_flat = values;
   assign word_idx   = `FSR_IDX_W'(avs_address >> `FSR_BYTE_SHIFT);
   assign mapped     = |hit;
   assign req        = avs_read | avs_write;

   // ------------------------------------------------------------
   // Register store
   // ------------------------------------------------------------

   // Each register follows the control loop only; the bus never writes it.
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_reg
         assign hit[gi] = (word_idx == IDX_TAB[gi]);
         assign store_flat[gi*32 +: 32] = store_q[gi];

         always_comb begin
            store_d[gi] = store_q[gi];
            if (update[gi]) begin
               store_d[gi] = value_flat[gi*32 +: 32];
            end
         end

         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               store_q[gi] <= `FSR_RESET_WORD;
            end else begin
               store_q[gi] <= store_d[gi];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Avalon-MM slave
   // ------------------------------------------------------------

   // Every access takes one wait cycle; read data is registered in it.
   always_comb begin
      ack_d   = req & ~ack_q;
      rdata_d = rdata_q;
      resp_d  = resp_q;
      if (req && !ack_q) begin
         rdata_d = `FSR_RESET_WORD;
         resp_d  = mapped ? `FSR_RESP_OKAY : `FSR_RESP_SLVERR;
         if (avs_read) begin
            for (int i = 0; i < N; i++) begin
               if (hit[i]) begin
                  rdata_d = store_q[i];
               end
            end
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ack_q   <= 1'h0;
         rdata_q <= `FSR_RESET_WORD;
         resp_q  <= `FSR_RESP_OKAY;
      end else begin
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
         resp_q  <= resp_d;
      end
   end

   assign avs_waitrequest = req & ~ack_q;
   assign avs_readdata    = rdata_q;
   assign avs_response    = resp_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------

   // Records whether the control loop has written any register yet.
   always_comb begin
      seen_d = seen_q | (|update);
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         seen_q <= 1'h0;
      end else begin
         seen_q <= seen_d;
      end
   end

   property p_alpha_capture;
      @(posedge clock) disable iff (!reset_n)
      update[`FSR_POS_ALPHA] |=>
         store_q[`FSR_POS_ALPHA] == $past(values.alpha_axis_voltage);
   endproperty
   a_alpha_capture: assert property (p_alpha_capture)
      else $error("alpha voltage not captured");

   property p_beta_read;
      @(posedge clock) disable iff (!reset_n)
      (avs_read && !avs_waitrequest && hit[`FSR_POS_BETA]) |->
         avs_readdata == $past(store_q[`FSR_POS_BETA]);
   endproperty
   a_beta_read: assert property (p_beta_read)
      else $error("beta voltage read wrong");

   property p_dcur_hold;
      @(posedge clock) disable iff (!reset_n)
      !update[`FSR_POS_DCUR] |=> $stable(store_q[`FSR_POS_DCUR]);
   endproperty
   a_dcur_hold: assert property (p_dcur_hold)
      else $error("direct current changed without update");

   property p_qcur_read;
      @(posedge clock) disable iff (!reset_n)
      (avs_read && avs_waitrequest && hit[`FSR_POS_QCUR]) |=>
         (!avs_waitrequest && avs_readdata == $past(store_q[`FSR_POS_QCUR]));
   endproperty
   a_qcur_read: assert property (p_qcur_read)
      else $error("quadrature current read wrong");

   property p_dvolt_capture;
      @(posedge clock) disable iff (!reset_n)
      update[`FSR_POS_DVOLT] ##1 !update[`FSR_POS_DVOLT] |->
         store_q[`FSR_POS_DVOLT] == $past(values.direct_axis_voltage);
   endproperty
   a_dvolt_capture: assert property (p_dvolt_capture)
      else $error("direct voltage not captured");

   property p_qvolt_resp;
      @(posedge clock) disable iff (!reset_n)
      (avs_read && hit[`FSR_POS_QVOLT] && !avs_waitrequest) |->
         (avs_response == `FSR_RESP_OKAY &&
          avs_readdata == $past(store_q[`FSR_POS_QVOLT]));
   endproperty
   a_qvolt_resp: assert property (p_qvolt_resp)
      else $error("quadrature voltage read wrong");

   property p_align_capture;
      @(posedge clock) disable iff (!reset_n)
      update[`FSR_POS_ALIGN] |=>
         store_q[`FSR_POS_ALIGN] == $past(values.align_current_reference);
   endproperty
   a_align_capture: assert property (p_align_capture)
      else $error("align reference not captured");

   property p_speed_read;
      @(posedge clock) disable iff (!reset_n)
      (avs_read && avs_waitrequest && hit[`FSR_POS_SPEED]) |=>
         avs_readdata == $past(store_q[`FSR_POS_SPEED]);
   endproperty
   a_speed_read: assert property (p_speed_read)
      else $error("speed reference read wrong");

   property p_reset_zero;
      @(posedge clock) disable iff (!reset_n)
      !seen_q |-> (store_flat == '0);
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("register not zero before first update");

   property p_write_no_effect;
      @(posedge clock) disable iff (!reset_n)
      (avs_write && update == '0) |=> $stable(store_flat);
   endproperty
   a_write_no_effect: assert property (p_write_no_effect)
      else $error("write changed a register");

   property p_wait_bound;
      @(posedge clock) disable iff (!reset_n)
      $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest;
   endproperty
   a_wait_bound: assert property (p_wait_bound)
      else $error("waitrequest not released after one cycle");

   property p_unmapped_error;
      @(posedge clock) disable iff (!reset_n)
      (req && !avs_waitrequest && !mapped) |->
         (avs_response == `FSR_RESP_SLVERR && avs_readdata == '0);
   endproperty
   a_unmapped_error: assert property (p_unmapped_error)
      else $error("unmapped access not flagged");

   // ------------------------------------------------------------
   // Per-register capture checks
   // ------------------------------------------------------------

   property p_beta_capture;
      @(posedge clock) disable iff (!reset_n)
      update[`FSR_POS_BETA] |=>
         store_q[`FSR_POS_BETA] == $past(values.beta_axis_voltage);
   endproperty
   a_beta_capture: assert property (p_beta_capture)
      else $error("beta voltage not captured");

   property p_dcur_capture;
      @(posedge clock) disable iff (!reset_n)
      update[`FSR_POS_DCUR] |=>
         store_q[`FSR_POS_DCUR] == $past(values.direct_axis_current);
   endproperty
   a_dcur_capture: assert property (p_dcur_capture)
      else $error("direct current not captured");

   property p_qcur_capture;
      @(posedge clock) disable iff (!reset_n)
      update[`FSR_POS_QCUR] |=>
         store_q[`FSR_POS_QCUR] == $past(values.quadrature_axis_current);
   endproperty
   a_qcur_capture: assert property (p_qcur_capture)
      else $error("quadrature current not captured");

   property p_qvolt_capture;
      @(posedge clock) disable iff (!reset_n)
      update[`FSR_POS_QVOLT] |=>
         store_q[`FSR_POS_QVOLT] == $past(values.quadrature_axis_voltage);
   endproperty
   a_qvolt_capture: assert property (p_qvolt_capture)
      else $error("quadrature voltage not captured");

   property p_speed_capture;
      @(posedge clock) disable iff (!reset_n)
      update[`FSR_POS_SPEED] |=>
         store_q[`FSR_POS_SPEED] == $past(values.open_loop_speed_reference);
   endproperty
   a_speed_capture: assert property (p_speed_capture)
      else $error("speed reference not captured");

   // ------------------------------------------------------------
   // Per-register read checks
   // ------------------------------------------------------------

   property p_alpha_read;
      @(posedge clock) disable iff (!reset_n)
      (avs_read && avs_waitrequest && hit[`FSR_POS_ALPHA]) |=>
         (!avs_waitrequest && avs_readdata == $past(store_q[`FSR_POS_ALPHA]));
   endproperty
   a_alpha_read: assert property (p_alpha_read)
      else $error("alpha voltage read wrong");

   property p_dcur_read;
      @(posedge clock) disable iff (!reset_n)
      (avs_read && avs_waitrequest && hit[`FSR_POS_DCUR]) |=>
         (!avs_waitrequest && avs_readdata == $past(store_q[`FSR_POS_DCUR]));
   endproperty
   a_dcur_read: assert property (p_dcur_read)
      else $error("direct current read wrong");

   property p_dvolt_read;
      @(posedge clock) disable iff (!reset_n)
      (avs_read && avs_waitrequest && hit[`FSR_POS_DVOLT]) |=>
         (!avs_waitrequest && avs_readdata == $past(store_q[`FSR_POS_DVOLT]));
   endproperty
   a_dvolt_read: assert property (p_dvolt_read)
      else $error("direct voltage read wrong");

   property p_align_read;
      @(posedge clock) disable iff (!reset_n)
      (avs_read && avs_waitrequest && hit[`FSR_POS_ALIGN]) |=>
         (!avs_waitrequest && avs_readdata == $past(store_q[`FSR_POS_ALIGN]));
   endproperty
   a_align_read: assert property (p_align_read)
      else $error("align reference read wrong");

   // ------------------------------------------------------------
   // Write checks
   // ------------------------------------------------------------

   property p_write_resp;
      @(posedge clock) disable iff (!reset_n)
      (avs_write && !avs_waitrequest && mapped) |->
         avs_response == `FSR_RESP_OKAY;
   endproperty
   a_write_resp: assert property (p_write_resp)
      else $error("write to mapped register not answered okay");

   property p_write_data_ignored;
      @(posedge clock) disable iff (!reset_n)
      (avs_write && (avs_byteenable != '0 || avs_writedata != '0) && update == '0) |=>
         $stable(store_flat);
   endproperty
   a_write_data_ignored: assert property (p_write_data_ignored)
      else $error("write data reached a register");

endmodule

// >>> bench/fsr_regs_test.sv
// Self-checking testbench for the field-oriented control readback register bank.
`include "fsr_consts.svh"

module fsr_regs_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic                 clock;
   logic                 reset_n;
   logic [12:0]          avs_address;
   logic                 avs_read;
   logic                 avs_write;
   logic [31:0]          avs_writedata;
   logic [3:0]           avs_byteenable;
   logic [31:0]          avs_readdata;
   logic [1:0]           avs_response;
   logic                 avs_waitrequest;
   fsr_pkg::fsr_values_s values;
   logic [7:0]           update;
   logic [10:0]          idx_tab [8];
   logic [31:0]          exp_tab [8];
   int                   error_cnt;
   int                   samples_checked;

   fsr_regs i_fsr_regs (
      .clock           (clock),
      .reset_n         (reset_n),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_response    (avs_response),
      .avs_waitrequest (avs_waitrequest),
      .values          (values),
      .update          (update)
   );

   always #5 clock = ~clock;

   // ------------------------------------------------------------
   // Reporting and comparison
   // ------------------------------------------------------------
   task complete_run;
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task check_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t word got %08h exp %08h", $time, got, exp);
      end
   endtask

   task check_resp(input logic [1:0] got, input logic [1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t resp got %0h exp %0h", $time, got, exp);
      end
   endtask

   // ------------------------------------------------------------
   // Bus and control-loop drivers
   // ------------------------------------------------------------
   task bus_op(input logic wr, input logic [10:0] idx, input logic [31:0] wd,
               output logic [31:0] rd, output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge clock);
      avs_address   <= {idx, 2'h0};
      avs_read      <= ~wr;
      avs_write     <= wr;
      avs_writedata <= wd;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 50);
      rd = avs_readdata;
      rs = avs_response;
      avs_read  <= 1'h0;
      avs_write <= 1'h0;
      if (avs_waitrequest !== 1'h0) begin
         error_cnt++;
         complete_run;
      end
   endtask

   task read_all;
      logic [31:0] rd;
      logic [1:0]  rs;
      for (int i = 0; i < 8; i++) begin
         bus_op(1'h0, idx_tab[i], 32'h00000000, rd, rs);
         check_word(rd, exp_tab[i]);
         check_resp(rs, `FSR_RESP_OKAY);
      end
   endtask

   // Only registers whose strobe is set take the new value.
   task load_values(input logic [7:0] mask, input logic [31:0] seed);
      @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         values[i*32 +: 32] <= seed ^ (32'h01000001 * i);
         if (mask[i])
            exp_tab[i] = seed ^ (32'h01000001 * i);
      end
      update <= mask;
      @(posedge clock);
      update <= 8'h00;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task test_reset_zero;
      read_all;
      $display("test_reset_zero done");
   endtask

   task test_all_update;
      load_values(8'hFF, 32'h87654321);
      read_all;
      $display("test_all_update done");
   endtask

   task test_single_update;
      load_values(8'h08, 32'h0F0FF0F0);
      read_all;
      $display("test_single_update done");
   endtask

   task test_write_ignored;
      logic [31:0] rd;
      logic [1:0]  rs;
      for (int i = 0; i < 8; i++) begin
         bus_op(1'h1, idx_tab[i], ~exp_tab[i], rd, rs);
         check_resp(rs, `FSR_RESP_OKAY);
      end
      read_all;
      $display("test_write_ignored done");
   endtask

   task test_unmapped;
      logic [31:0] rd;
      logic [1:0]  rs;
      bus_op(1'h0, 11'h4DC, 32'h00000000, rd, rs);
      check_word(rd, 32'h00000000);
      check_resp(rs, `FSR_RESP_SLVERR);
      bus_op(1'h1, 11'h4DC, 32'hFFFFFFFF, rd, rs);
      check_resp(rs, `FSR_RESP_SLVERR);
      read_all;
      $display("test_unmapped done");
   endtask

   task test_mid_reset;
      @(posedge clock);
      reset_n <= 1'h0;
      repeat (4) @(posedge clock);
      reset_n <= 1'h1;
      for (int i = 0; i < 8; i++)
         exp_tab[i] = `FSR_RESET_WORD;
      read_all;
      $display("test_mid_reset done");
   endtask

   initial begin
      clock = 1'h0;
      reset_n = 1'h0;
      avs_address = 13'h0000;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hF;
      values = '0;
      update = 8'h00;
      error_cnt = 0;
      samples_checked = 0;
      idx_tab = '{`FSR_IDX_ALPHA, `FSR_IDX_BETA, `FSR_IDX_DCUR, `FSR_IDX_QCUR,
                  `FSR_IDX_DVOLT, `FSR_IDX_QVOLT, `FSR_IDX_ALIGN, `FSR_IDX_SPEED};
      for (int i = 0; i < 8; i++)
         exp_tab[i] = `FSR_RESET_WORD;
      repeat (4) @(posedge clock);
      reset_n <= 1'h1;
      test_reset_zero;
      test_all_update;
      test_single_update;
      test_write_ignored;
      test_unmapped;
      test_mid_reset;
      complete_run;
   end
endmodule
